/* File: include/edge_if.sv */
`timescale 1ns/1ps
interface edge_if;
  logic rise;
  logic fall;
  modport src (output rise, output fall);
  modport dst (input rise, input fall);
endinterface

/* File: include/ic_pkg.sv */
package ic_pkg;

  // ****************************************
  // Sizes
  // ****************************************
  localparam int NUM_CH = 4;
  localparam int DEPTH = 4;
  localparam int AW = 4;

  // ****************************************
  // Register indices within a channel
  // ****************************************
  localparam logic [1:0] REG_CTRL1 = 2'h0;
  localparam logic [1:0] REG_CTRL2 = 2'h1;
  localparam logic [1:0] REG_BUF = 2'h2;
  localparam logic [1:0] REG_CTR = 2'h3;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int B_IDLE = 13;
  localparam int B_TSEL = 10;
  localparam int B_CPI = 5;
  localparam int B_OVF = 4;
  localparam int B_BNE = 3;
  localparam int B_MODE = 0;
  localparam int B_CASC = 8;
  localparam int B_TRIG = 7;
  localparam int B_TSTAT = 6;
  localparam int B_SSEL = 0;

  // ****************************************
  // Reset values and counts
  // ****************************************
  localparam logic [4:0] SSEL_RST = 5'h0D;
  localparam logic [4:0] SSEL_NONE_LO = 5'h00;
  localparam logic [4:0] SSEL_NONE_HI = 5'h1F;
  localparam logic [3:0] PRE4_LAST = 4'h3;
  localparam logic [3:0] PRE16_LAST = 4'hF;
  localparam logic [15:0] CTR_MAX = 16'hFFFF;

  typedef enum logic [2:0] {
    M_OFF = 3'h0, M_EDGE = 3'h1, M_FALL = 3'h2, M_RISE = 3'h3,
    M_PRE4 = 3'h4, M_PRE16 = 3'h5, M_UNUSED = 3'h6, M_WAKE = 3'h7
  } mode_t;

  typedef enum logic [2:0] {
    CS_T3 = 3'h0, CS_T2 = 3'h1, CS_T4 = 3'h2, CS_T5 = 3'h3,
    CS_T1 = 3'h4, CS_FP = 3'h7
  } tsel_t;

endpackage

/* File: sim/input_capture_channel_test.sv */
`timescale 1ns/1ps
module input_capture_channel_test;
  // ****************************************
  // Stimulus and wiring
  // ****************************************
  logic mclk;
  logic sys_rst;
  logic [3:0] reg_addr;
  logic [15:0] wr_data;
  logic wr_stb;
  logic rd_stb;
  logic [15:0] rd_data;
  logic [1:0] cap_pin;
  logic [4:0] tmr_tick;
  logic [31:0] sync_src;
  logic cpu_idle;
  logic cpu_sleep;
  logic [1:0] cap_irq;
  int failures = 0;
  int checks_done = 0;
  int irq_n = 0;
  int irq1_n = 0;

  // Two channels only, so channel 2 addresses are unmapped
  input_capture_channel #(.NUM_CH(2), .DEPTH(4)) u_input_capture_channel (
    .mclk(mclk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .wr_data(wr_data), .wr_stb(wr_stb), .rd_stb(rd_stb),
    .rd_data(rd_data), .cap_pin(cap_pin), .tmr_tick(tmr_tick),
    .sync_src(sync_src), .cpu_idle(cpu_idle), .cpu_sleep(cpu_sleep),
    .cap_irq(cap_irq)
  );
  pin_source #(.NUM_CH(2)) u_pin_source (.mclk(mclk), .pin(cap_pin));

  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  // Counted off-edge so clearing at posedge never races
  always @(negedge mclk) begin
    if (cap_irq[0] === 1'b1) irq_n++;
    if (cap_irq[1] === 1'b1) irq1_n++;
  end

  // ****************************************
  // Bus and compare helpers
  // ****************************************
  task automatic chk(input string what, input logic [15:0] exp,
                     input logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      $display("wrong value %s expected %h seen %h", what, exp, got);
      failures++;
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge mclk);
    reg_addr <= a;
    wr_data <= d;
    wr_stb <= 1'b1;
    @(posedge mclk);
    wr_stb <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge mclk);
    reg_addr <= a;
    rd_stb <= 1'b1;
    @(posedge mclk);
    rd_stb <= 1'b0;
    @(negedge mclk);
    d = rd_data;
  endtask

  task automatic report_and_stop;
    if (failures == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic reset_values;
    logic [15:0] d;
    rd(4'h0, d);
    chk("ctrl1 reset", 16'h0000, d);
    rd(4'h1, d);
    chk("ctrl2 reset", 16'h000D, d);
    rd(4'h2, d);
    chk("empty buffer", 16'h0000, d);
    wr(4'h8, 16'h1C03);
    rd(4'h8, d);
    chk("unmapped", 16'h0000, d);
    wr(4'h1, 16'h0000);
  endtask

  // Pulse, rewrite ctl to try clearing flags, then drain and time
  task automatic run_case(input logic [15:0] ctl, input int np,
                          input int exp_n, input int exp_irq,
                          input logic ovf, input int gap);
    logic [15:0] d;
    logic [15:0] prev;
    int n;
    wr(4'h0, ctl);
    irq_n = 0;
    u_pin_source.pulse(0, np, 3, 3);
    repeat (8) @(posedge mclk);
    wr(4'h0, ctl);
    if (exp_irq >= 0) chk("irq count", exp_irq[15:0], irq_n[15:0]);
    rd(4'h0, d);
    chk("overflow", {15'h0000, ovf}, {15'h0000, d[4]});
    chk("not empty", {15'h0000, exp_n > 0}, {15'h0000, d[3]});
    n = 0;
    repeat (6) begin
      rd(4'h0, d);
      if (d[3] === 1'b1) begin
        rd(4'h2, d);
        if (n > 0 && gap >= 0) chk("gap", gap[15:0], d - prev);
        prev = d;
        n++;
      end
    end
    chk("entries", exp_n[15:0], n[15:0]);
    wr(4'h0, 16'h0000);
    rd(4'h0, d);
    chk("ctrl1 off", 16'h0000, d);
  endtask

  task automatic modes;
    run_case(16'h1C00, 4, 0, 0, 1'b0, -1);
    run_case(16'h1C06, 4, 0, 0, 1'b0, -1);
    run_case(16'h1C01, 2, 4, 4, 1'b0, 3);
    run_case(16'h1C02, 4, 4, 4, 1'b0, 6);
    run_case(16'h1C03, 4, 4, 4, 1'b0, 6);
    run_case(16'h1C04, 16, 4, 4, 1'b0, 24);
    run_case(16'h1C05, 16, 1, 1, 1'b0, -1);
    run_case(16'h1C07, 4, 0, 0, 1'b0, -1);
    @(posedge mclk);
    cpu_sleep <= 1'b1;
    run_case(16'h1C67, 4, 0, 4, 1'b0, -1);
    @(posedge mclk);
    cpu_sleep <= 1'b0;
  endtask

  task automatic per_irq_and_idle;
    run_case(16'h1C63, 4, 4, 1, 1'b0, 6);
    run_case(16'h1C23, 4, 4, 2, 1'b0, 6);
    run_case(16'h1C43, 3, 3, 1, 1'b0, 6);
    run_case(16'h1C61, 2, 4, 4, 1'b0, 3);
    run_case(16'h1C03, 5, 4, -1, 1'b1, 6);
    @(posedge mclk);
    cpu_idle <= 1'b1;
    run_case(16'h3C03, 4, 0, 0, 1'b0, -1);
    run_case(16'h1C03, 4, 4, 4, 1'b0, 6);
    @(posedge mclk);
    cpu_idle <= 1'b0;
  endtask

  task automatic clock_select;
    // Third timer never ticks here, so the counter stands still
    run_case(16'h0003, 4, 4, 4, 1'b0, 0);
    @(posedge mclk);
    tmr_tick <= 5'h01;
    run_case(16'h1003, 4, 4, 4, 1'b0, 6);
    @(posedge mclk);
    tmr_tick <= 5'h02;
    run_case(16'h0403, 4, 4, 4, 1'b0, 6);
    run_case(16'h1003, 4, 4, 4, 1'b0, 0);
    run_case(16'h0803, 4, 4, 4, 1'b0, 0);
    run_case(16'h0C03, 4, 4, 4, 1'b0, 0);
    run_case(16'h1403, 4, 4, 4, 1'b0, 0);
    @(posedge mclk);
    tmr_tick <= 5'h08;
    run_case(16'h0803, 4, 4, 4, 1'b0, 6);
    run_case(16'h0C03, 4, 4, 4, 1'b0, 0);
    @(posedge mclk);
    tmr_tick <= 5'h10;
    run_case(16'h0C03, 4, 4, 4, 1'b0, 6);
    @(posedge mclk);
    tmr_tick <= 5'h04;
    run_case(16'h0003, 4, 4, 4, 1'b0, 6);
    @(posedge mclk);
    tmr_tick <= 5'h00;
  endtask

  task automatic trigger_hold;
    logic [15:0] a;
    logic [15:0] b;
    wr(4'h1, 16'h0080);
    wr(4'h0, 16'h1C03);
    rd(4'h3, a);
    rd(4'h3, b);
    chk("held counter", 16'h0000, a | b);
    wr(4'h1, 16'h00C0);
    rd(4'h3, a);
    rd(4'h3, b);
    chk("running counter", 16'h0002, b - a);
    // Source 13 pulses twice: sync clears, then trigger starts
    wr(4'h1, 16'h000D);
    @(posedge mclk);
    sync_src <= 32'h00002000;
    @(posedge mclk);
    sync_src <= 32'h00000000;
    rd(4'h3, a);
    chk("synced counter", 16'h0001, a);
    wr(4'h1, 16'h008D);
    @(posedge mclk);
    sync_src <= 32'h00002000;
    @(posedge mclk);
    sync_src <= 32'h00000000;
    rd(4'h3, a);
    rd(4'h1, b);
    chk("triggered counter", 16'h0001, a);
    chk("trigger status", 16'h00CD, b);
    wr(4'h1, 16'h0000);
    wr(4'h0, 16'h0000);
  endtask

  // Low word wraps into the high word; odd pin pushes both buffers
  task automatic cascade;
    logic [15:0] d;
    wr(4'h1, 16'h0100);
    wr(4'h5, 16'h0100);
    wr(4'h4, 16'h1C03);
    wr(4'h3, 16'hFFF0);
    wr(4'h7, 16'h0000);
    repeat (20) @(posedge mclk);
    rd(4'h7, d);
    chk("high word carry", 16'h0001, d);
    irq1_n = 0;
    u_pin_source.pulse(1, 1, 3, 3);
    repeat (8) @(posedge mclk);
    chk("odd irq", 16'h0001, irq1_n[15:0]);
    rd(4'h6, d);
    chk("high word capture", 16'h0001, d);
    rd(4'h0, d);
    chk("low half pushed", 16'h0001, {15'h0000, d[3]});
  endtask

  // ****************************************
  // Main sequence and watchdog
  // ****************************************
  initial begin
    sys_rst = 1'b1;
    reg_addr = 4'h0;
    wr_data = 16'h0000;
    wr_stb = 1'b0;
    rd_stb = 1'b0;
    tmr_tick = 5'h00;
    sync_src = 32'h00000000;
    cpu_idle = 1'b0;
    cpu_sleep = 1'b0;
    repeat (4) @(posedge mclk);
    sys_rst <= 1'b0;
    reset_values;
    modes;
    per_irq_and_idle;
    clock_select;
    trigger_hold;
    cascade;
    report_and_stop;
  end

  initial begin
    #200000;
    failures++;
    report_and_stop;
  end
endmodule

/* File: sim/pin_source.sv */
`timescale 1ns/1ps
// ****************************************
// External signal whose edges get timestamped
// ****************************************
module pin_source #(
  parameter int NUM_CH = 2
) (
  input wire logic mclk,
  output logic [NUM_CH-1:0] pin
);
  initial begin
    pin = '0;
  end

  // Pulses stay at least 3 cycles wide; one-cycle ones are lost
  task automatic pulse(input int ch, input int n, input int hi,
                       input int lo);
    repeat (n) begin
      @(posedge mclk);
      pin[ch] <= 1'b1;
      repeat (hi) @(posedge mclk);
      pin[ch] <= 1'b0;
      repeat (lo - 1) @(posedge mclk);
    end
  endtask
endmodule

/* File: verilog/edge_sync.sv */
`timescale 1ns/1ps
module edge_sync (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic pin,
  edge_if.src ev
);

  // ****************************************
  // Three-stage synchroniser with agreement
  // ****************************************
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic lvl;
    logic rise;
    logic fall;
  } st_t;

  st_t s_q;
  st_t s_d;

  always_comb begin
    s_d = s_q;
    s_d.s1 = pin;
    s_d.s2 = s_q.s1;
    s_d.s3 = s_q.s2;
    s_d.rise = 1'b0;
    s_d.fall = 1'b0;
    // Stages two and three must agree, so a one-cycle glitch is dropped
    if (s_q.s2 == s_q.s3 && s_q.s3 != s_q.lvl) begin
      s_d.lvl = s_q.s3;
      s_d.rise = s_q.s3;
      s_d.fall = ~s_q.s3;
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign ev.rise = s_q.rise;
  assign ev.fall = s_q.fall;

endmodule

/* File: verilog/input_capture_channel.sv */
`timescale 1ns/1ps
// What this block does
// - Up to four independent channels, each with control, counter, buffer.
// - Adjacent even/odd channels cascade into one 32-bit capture unit.
// - Counter runs synchronised or triggered, from 30 selectable sources.
// - Each channel keeps captured values in a four-entry FIFO.
// - Each channel has its own 16-bit counter with six clock sources.
// - Idle-stop bit 13 set halts the channel while the CPU idles.
// - Clock select: 111 fast, 100 t1, 011 t5, 010 t4, 001 t2, 000 t3.
// - Interrupt after every first, second, third or fourth capture.
// - Captures-per-interrupt ignored in every-edge and wake-pin modes.
// - Overflow flag bit 4 set and cleared by hardware only.
// - Buffer-not-empty bit 3 reads one while unread values remain.
// - Mode 111: rising-edge interrupt in sleep or idle only.
// - Mode 101 captures every 16th rise, mode 100 every 4th.
// - Mode 011 captures every rise, mode 010 every fall.
// - Mode 001 captures every edge, both directions.
// - Modes 000 and 110 leave the channel disabled.
// - Trigger mode bit: source starts counter; else source syncs it.
// - Trigger status set by source or software; clear holds counter zero.
module input_capture_channel #(
  parameter int NUM_CH = ic_pkg::NUM_CH,
  parameter int DEPTH = ic_pkg::DEPTH
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic [ic_pkg::AW-1:0] reg_addr,
  input wire logic [15:0] wr_data,
  input wire logic wr_stb,
  input wire logic rd_stb,
  output logic [15:0] rd_data,
  input wire logic [NUM_CH-1:0] cap_pin,
  input wire logic [4:0] tmr_tick,
  input wire logic [31:0] sync_src,
  input wire logic cpu_idle,
  input wire logic cpu_sleep,
  output logic [NUM_CH-1:0] cap_irq
);

  localparam int PW = $clog2(DEPTH);

  if (NUM_CH < 1 || NUM_CH > 4 || DEPTH < 2 ||
      (DEPTH & (DEPTH - 1)) != 0) begin : g_bad
    $error("input_capture_channel: unsupported NUM_CH or DEPTH");
  end

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic [NUM_CH-1:0] idle;
    logic [NUM_CH-1:0][2:0] tsel;
    logic [NUM_CH-1:0][1:0] cpi;
    logic [NUM_CH-1:0] ovf;
    logic [NUM_CH-1:0][2:0] mode;
    logic [NUM_CH-1:0] casc;
    logic [NUM_CH-1:0] trig;
    logic [NUM_CH-1:0] tstat;
    logic [NUM_CH-1:0][4:0] ssel;
    logic [NUM_CH-1:0][15:0] ctr;
    logic [NUM_CH-1:0][3:0] pre;
    logic [NUM_CH-1:0][1:0] icnt;
    logic [NUM_CH-1:0][DEPTH-1:0][15:0] mem;
    logic [NUM_CH-1:0][PW-1:0] wp;
    logic [NUM_CH-1:0][PW-1:0] rp;
    logic [NUM_CH-1:0][PW:0] cnt;
    logic [NUM_CH-1:0] irq;
    logic [15:0] rdata;
  } st_t;

  st_t s_q;
  st_t s_d;
  logic [NUM_CH-1:0] rise;
  logic [NUM_CH-1:0] fall;
  logic [NUM_CH-1:0] tk;
  logic [NUM_CH-1:0] src;
  logic [NUM_CH-1:0] evr;
  logic [NUM_CH-1:0] cap;
  logic [NUM_CH-1:0] halt;
  logic [NUM_CH-1:0] pop;
  logic [NUM_CH-1:0] pair;

  // ****************************************
  // Input edge detectors
  // ****************************************
  for (genvar g = 0; g < NUM_CH; g++) begin : g_ch
    edge_if e ();
    edge_sync u_sync (
      .mclk(mclk),
      .sys_rst(sys_rst),
      .pin(cap_pin[g]),
      .ev(e)
    );
    assign rise[g] = e.rise;
    assign fall[g] = e.fall;
  end

  function automatic logic tick_of(input logic [2:0] sel);
    case (ic_pkg::tsel_t'(sel))
      ic_pkg::CS_FP: tick_of = 1'b1;
      ic_pkg::CS_T1: tick_of = tmr_tick[0];
      ic_pkg::CS_T2: tick_of = tmr_tick[1];
      ic_pkg::CS_T3: tick_of = tmr_tick[2];
      ic_pkg::CS_T4: tick_of = tmr_tick[3];
      ic_pkg::CS_T5: tick_of = tmr_tick[4];
      default: tick_of = 1'b0;
    endcase
  endfunction

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    int ch;
    int m;
    logic hit;
    logic act;
    logic inc;
    logic [PW:0] c;
    logic [15:0] v;
    ch = 0;
    m = 0;
    hit = 1'b0;
    act = 1'b0;
    inc = 1'b0;
    c = '0;
    v = '0;
    s_d = s_q;
    s_d.irq = '0;
    s_d.rdata = '0;
    tk = '0;
    src = '0;
    evr = '0;
    cap = '0;
    halt = '0;
    pop = '0;
    pair = '0;
    ch = int'(reg_addr[ic_pkg::AW-1:2]);
    hit = ch < NUM_CH;

    // Register writes come first so hardware sets win below
    if (wr_stb && hit) begin
      case (reg_addr[1:0])
        ic_pkg::REG_CTRL1: begin
          s_d.idle[ch] = wr_data[ic_pkg::B_IDLE];
          s_d.tsel[ch] = wr_data[ic_pkg::B_TSEL +: 3];
          s_d.cpi[ch] = wr_data[ic_pkg::B_CPI +: 2];
          s_d.mode[ch] = wr_data[ic_pkg::B_MODE +: 3];
        end
        ic_pkg::REG_CTRL2: begin
          s_d.casc[ch] = wr_data[ic_pkg::B_CASC];
          s_d.trig[ch] = wr_data[ic_pkg::B_TRIG];
          s_d.tstat[ch] = wr_data[ic_pkg::B_TSTAT];
          s_d.ssel[ch] = wr_data[ic_pkg::B_SSEL +: 5];
        end
        default: begin
        end
      endcase
    end

    for (int i = 0; i < NUM_CH; i++) begin
      halt[i] = s_q.idle[i] & cpu_idle;
      tk[i] = tick_of(s_q.tsel[i]) & ~halt[i];
      if (s_q.ssel[i] != ic_pkg::SSEL_NONE_LO &&
          s_q.ssel[i] != ic_pkg::SSEL_NONE_HI) begin
        src[i] = sync_src[s_q.ssel[i]];
      end
      if ((i | 1) < NUM_CH) begin
        pair[i] = s_q.casc[i & ~1] & s_q.casc[i | 1];
      end
      if (!halt[i]) begin
        case (ic_pkg::mode_t'(s_q.mode[i]))
          ic_pkg::M_EDGE: evr[i] = rise[i] | fall[i];
          ic_pkg::M_FALL: evr[i] = fall[i];
          ic_pkg::M_RISE: evr[i] = rise[i];
          ic_pkg::M_PRE4: begin
            evr[i] = rise[i] && s_q.pre[i] == ic_pkg::PRE4_LAST;
          end
          ic_pkg::M_PRE16: begin
            evr[i] = rise[i] && s_q.pre[i] == ic_pkg::PRE16_LAST;
          end
          default: evr[i] = 1'b0;
        endcase
      end
      if (s_q.mode[i] == ic_pkg::M_PRE4 ||
          s_q.mode[i] == ic_pkg::M_PRE16) begin
        if (rise[i] && !halt[i]) begin
          s_d.pre[i] = evr[i] ? 4'h0 : s_q.pre[i] + 4'h1;
        end
      end else begin
        s_d.pre[i] = '0;
      end
    end

    for (int i = 0; i < NUM_CH; i++) begin
      // A cascaded pair follows the odd channel's settings
      m = pair[i] ? (i | 1) : i;
      act = s_q.mode[m] >= ic_pkg::M_EDGE && s_q.mode[m] <= ic_pkg::M_PRE16;
      inc = tk[m] & act & (~s_q.trig[m] | s_q.tstat[m]);
      if (pair[i] && (i % 2) == 1) begin
        inc = inc && s_q.ctr[i & ~1] == ic_pkg::CTR_MAX;
      end
      if (!s_q.trig[m] && src[m]) begin
        s_d.ctr[i] = '0;
      end else if (s_q.trig[m] && !s_q.tstat[m]) begin
        s_d.ctr[i] = '0;
      end else if (inc) begin
        s_d.ctr[i] = s_q.ctr[i] + 16'h0001;
      end
      if (s_q.trig[i] && src[i]) begin
        s_d.tstat[i] = 1'b1;
      end

      cap[i] = evr[m];
      pop[i] = rd_stb && hit && ch == i && reg_addr[1:0] == ic_pkg::REG_BUF &&
               s_q.cnt[i] != '0;
      c = s_q.cnt[i];
      if (pop[i]) begin
        s_d.rp[i] = s_q.rp[i] + 1'b1;
        c = c - 1'b1;
      end
      if (s_q.mode[i] == ic_pkg::M_OFF) begin
        s_d.ovf[i] = 1'b0;
        s_d.icnt[i] = '0;
      end
      if (cap[i]) begin
        if (c < (PW + 1)'(DEPTH)) begin
          s_d.mem[i][s_q.wp[i]] = s_q.ctr[i];
          s_d.wp[i] = s_q.wp[i] + 1'b1;
          c = c + 1'b1;
        end else begin
          s_d.ovf[i] = 1'b1;
        end
      end
      s_d.cnt[i] = c;

      if (s_q.mode[m] == ic_pkg::M_WAKE) begin
        // Wake pin ignores idle stop and every other control bit
        s_d.irq[i] = rise[i] & (cpu_sleep | cpu_idle);
      end else if (cap[i]) begin
        if (s_q.mode[m] == ic_pkg::M_EDGE) begin
          s_d.irq[i] = 1'b1;
        end else if (s_q.icnt[i] == s_q.cpi[m]) begin
          s_d.irq[i] = 1'b1;
          s_d.icnt[i] = '0;
        end else begin
          s_d.icnt[i] = s_q.icnt[i] + 2'h1;
        end
      end
    end

    // Counter write overrides counting in the same cycle
    if (wr_stb && hit && reg_addr[1:0] == ic_pkg::REG_CTR) begin
      s_d.ctr[ch] = wr_data;
    end

    if (rd_stb && hit) begin
      case (reg_addr[1:0])
        ic_pkg::REG_CTRL1: begin
          v[ic_pkg::B_IDLE] = s_q.idle[ch];
          v[ic_pkg::B_TSEL +: 3] = s_q.tsel[ch];
          v[ic_pkg::B_CPI +: 2] = s_q.cpi[ch];
          v[ic_pkg::B_OVF] = s_q.ovf[ch];
          v[ic_pkg::B_BNE] = s_q.cnt[ch] != '0;
          v[ic_pkg::B_MODE +: 3] = s_q.mode[ch];
        end
        ic_pkg::REG_CTRL2: begin
          v[ic_pkg::B_CASC] = s_q.casc[ch];
          v[ic_pkg::B_TRIG] = s_q.trig[ch];
          v[ic_pkg::B_TSTAT] = s_q.tstat[ch];
          v[ic_pkg::B_SSEL +: 5] = s_q.ssel[ch];
        end
        ic_pkg::REG_BUF: begin
          if (s_q.cnt[ch] != '0) begin
            v = s_q.mem[ch][s_q.rp[ch]];
          end
        end
        default: v = s_q.ctr[ch];
      endcase
      s_d.rdata = v;
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      s_q <= '0;
      s_q.ssel <= {NUM_CH{ic_pkg::SSEL_RST}};
    end else begin
      s_q <= s_d;
    end
  end

  assign rd_data = s_q.rdata;
  assign cap_irq = s_q.irq;

  // ****************************************
  // Checks on channel zero
  // ****************************************
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (sys_rst);

  localparam logic [ic_pkg::AW-1:0] A_C1 = {2'h0, ic_pkg::REG_CTRL1};
  localparam logic [ic_pkg::AW-1:0] A_BUF = {2'h0, ic_pkg::REG_BUF};

  sequence s_pop;
    rd_stb && reg_addr == A_BUF && s_q.cnt[0] != '0;
  endsequence
  sequence s_full_cap;
    cap[0] && s_q.cnt[0] == (PW + 1)'(DEPTH) && !pop[0];
  endsequence

  property p_fifo;
    s_pop |=> rd_data == $past(s_q.mem[0][s_q.rp[0]]);
  endproperty
  a_fifo: assert property (p_fifo) else $error("wrong buffer word");

  property p_full;
    s_full_cap |=> s_q.ovf[0] && s_q.cnt[0] == (PW + 1)'(DEPTH) &&
      s_q.wp[0] == $past(s_q.wp[0]);
  endproperty
  a_full: assert property (p_full) else $error("overflow mishandled");

  property p_ovf_rose;
    $rose(s_q.ovf[0]) |-> $past(s_q.cnt[0]) == (PW + 1)'(DEPTH);
  endproperty
  a_ovf_rose: assert property (p_ovf_rose) else $error("bad overflow");

  property p_bne;
    rd_stb && reg_addr == A_C1 |=>
      rd_data[ic_pkg::B_BNE] == ($past(s_q.cnt[0]) != '0);
  endproperty
  a_bne: assert property (p_bne) else $error("not-empty flag wrong");

  property p_pre4;
    s_q.mode[0] == ic_pkg::M_PRE4 && !pair[0] && rise[0] && !halt[0] &&
      s_q.pre[0] != ic_pkg::PRE4_LAST |=> s_q.cnt[0] <= $past(s_q.cnt[0]);
  endproperty
  a_pre4: assert property (p_pre4) else $error("early prescaled capture");

  property p_fall;
    s_q.mode[0] == ic_pkg::M_FALL && !pair[0] && fall[0] && !halt[0] &&
      s_q.cnt[0] == '0 ##1 !pop[0] |-> s_q.cnt[0] == (PW + 1)'(1);
  endproperty
  a_fall: assert property (p_fall) else $error("falling edge lost");

  property p_off;
    s_q.mode[0] == ic_pkg::M_OFF && !pair[0] |=> !s_q.irq[0] &&
      s_q.wp[0] == $past(s_q.wp[0]);
  endproperty
  a_off: assert property (p_off) else $error("disabled channel acted");

  property p_hold;
    s_q.trig[0] && !s_q.tstat[0] && !pair[0] &&
      !(wr_stb && reg_addr[1:0] == ic_pkg::REG_CTR) |=> s_q.ctr[0] == '0;
  endproperty
  a_hold: assert property (p_hold) else $error("counter not held");

  property p_cpi;
    s_q.irq[0] && !$past(pair[0]) &&
      $past(s_q.mode[0]) inside {ic_pkg::M_FALL, ic_pkg::M_RISE,
      ic_pkg::M_PRE4, ic_pkg::M_PRE16} |->
      $past(s_q.icnt[0]) == $past(s_q.cpi[0]);
  endproperty
  a_cpi: assert property (p_cpi) else $error("interrupt count wrong");

  property p_wake;
    s_q.mode[0] == ic_pkg::M_WAKE && !pair[0] && rise[0] && cpu_sleep |=>
      s_q.irq[0] && s_q.cnt[0] <= $past(s_q.cnt[0]);
  endproperty
  a_wake: assert property (p_wake) else $error("wake interrupt wrong");

endmodule
